/* cpu_if_el3_binary_point_ctrl.sv */
`include "cpu_if_ctl_defs.svh"
`default_nettype none
module cpu_if_el3_binary_point_ctrl
  import cpu_if_ctl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire exc_level_t EL_IN,
  input wire logic SECURE_IN,
  input wire sysreg_req_t REQ_IN,
  input wire logic BP1_ACCESS_IN,
  input wire logic BP_WRITE_IN,
  input wire logic [2:0] BP_WDATA_IN,
  input wire logic EOI_IN,
  input wire logic DIR_IN,
  input wire logic TOP_LEVEL_INT_IN,
  output logic ACK_OUT,
  output logic UNDEF_OUT,
  output logic [63:0] RDATA_OUT,
  output logic [2:0] BP_RDATA_OUT,
  output logic [2:0] GROUP1_POINT_OUT,
  output logic [2:0] GROUP0_POINT_OUT,
  output logic DROP_OUT,
  output logic DEACT_OUT
);
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [63:0] ctl_r;
  logic [2:0] bp0_r;
  logic [2:0] bp1_ns_r;
  logic [2:0] bp1_s_r;
  acc_state_t acc_r;
  acc_state_t acc_nxt;
  logic [63:0] rdata_r;
  logic [63:0] rdata_nxt;
  logic top_hit;
  logic el1_hit;
  logic shared_sel;
  logic split_sel;
  completion_act_t act;

  // World-banked bit: the secure copy or the non-secure copy
  function automatic logic pick_world(input logic sec, input logic s_bit, input logic ns_bit);
    logic sel;
    sel = sec ? s_bit : ns_bit;
    return sel;
  endfunction

  // Point register that the current world's group1 view names
  function automatic logic [2:0] pick_point(input logic sec, input logic [2:0] s_pt,
      input logic [2:0] ns_pt);
    logic [2:0] pt;
    pt = sec ? s_pt : ns_pt;
    return pt;
  endfunction

  function automatic logic [63:0] el1_view(input logic [63:0] c, input logic sec);
    logic [63:0] v;
    v = `CTL_RESET;
    // EL1 view bits alias the top register storage, so no second copy can drift
    v[`FLD_VIEW_SHARED] = pick_world(sec, c[`FLD_SHARED_S], c[`FLD_SHARED_NS]);
    v[`FLD_VIEW_SPLIT] = pick_world(sec, c[`FLD_SPLIT_S], c[`FLD_SPLIT_NS]);
    return v;
  endfunction

  assign top_hit = REQ_IN.valid && (REQ_IN.enc == `ENC_TOP_CTL);
  assign el1_hit = REQ_IN.valid && (REQ_IN.enc == `ENC_EL1_CTL) && (EL_IN != EL_0);

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  always_comb begin
    acc_nxt = ACC_IDLE;
    rdata_nxt = rdata_r;
    if (top_hit) begin
      if (EL_IN == EL_3) begin
        acc_nxt = ACC_DONE;
        rdata_nxt = ctl_r & `CTL_RW_MASK;
      end else begin
        acc_nxt = ACC_UNDEF;
      end
    end else if (el1_hit) begin
      acc_nxt = ACC_DONE;
      rdata_nxt = el1_view(ctl_r, SECURE_IN);
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acc_r <= ACC_IDLE;
      rdata_r <= `CTL_RESET;
    end else begin
      acc_r <= acc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ------------------------------------------------------------
  // Control register; writes land at the clock edge, so later ops see them
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctl_r <= `CTL_RESET;
    end else if (top_hit && REQ_IN.write && EL_IN == EL_3) begin
      ctl_r <= REQ_IN.wdata & `CTL_RW_MASK;
    end else if (el1_hit && REQ_IN.write) begin
      if (SECURE_IN) begin
        ctl_r[`FLD_SHARED_S] <= REQ_IN.wdata[`FLD_VIEW_SHARED];
        ctl_r[`FLD_SPLIT_S] <= REQ_IN.wdata[`FLD_VIEW_SPLIT];
      end else begin
        ctl_r[`FLD_SHARED_NS] <= REQ_IN.wdata[`FLD_VIEW_SHARED];
        ctl_r[`FLD_SPLIT_NS] <= REQ_IN.wdata[`FLD_VIEW_SPLIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Binary point storage and redirection
  // ------------------------------------------------------------
  // One select per world; the other world's bit is left alone
  assign shared_sel = pick_world(SECURE_IN, ctl_r[`FLD_SHARED_S], ctl_r[`FLD_SHARED_NS]);

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bp0_r <= `BPR_RESET;
      bp1_ns_r <= `BPR_RESET;
      bp1_s_r <= `BPR_RESET;
    end else if (BP_WRITE_IN) begin
      // Group1 views fold onto group0 while the shared bit is set
      if (!BP1_ACCESS_IN || shared_sel) begin
        bp0_r <= BP_WDATA_IN;
      end else if (SECURE_IN) begin
        bp1_s_r <= BP_WDATA_IN;
      end else begin
        bp1_ns_r <= BP_WDATA_IN;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      BP_RDATA_OUT <= `BPR_RESET;
    end else if (!BP1_ACCESS_IN || shared_sel) begin
      BP_RDATA_OUT <= bp0_r;
    end else begin
      BP_RDATA_OUT <= pick_point(SECURE_IN, bp1_s_r, bp1_ns_r);
    end
  end

  // Effective preemption points for the priority logic
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      GROUP0_POINT_OUT <= `BPR_RESET;
      GROUP1_POINT_OUT <= `BPR_RESET;
    end else begin
      GROUP0_POINT_OUT <= bp0_r;
      if (shared_sel) begin
        GROUP1_POINT_OUT <= bp0_r;
      end else begin
        GROUP1_POINT_OUT <= pick_point(SECURE_IN, bp1_s_r, bp1_ns_r);
      end
    end
  end

  // ------------------------------------------------------------
  // Completion handling
  // ------------------------------------------------------------
  always_comb begin
    if (TOP_LEVEL_INT_IN) begin
      split_sel = ctl_r[`FLD_SPLIT_TOP];
    end else begin
      split_sel = pick_world(SECURE_IN, ctl_r[`FLD_SPLIT_S], ctl_r[`FLD_SPLIT_NS]);
    end
  end

  completion_decode u_completion (
    .split_in(split_sel),
    .eoi_in(EOI_IN),
    .dir_in(DIR_IN),
    .act_out(act)
  );

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      DROP_OUT <= 1'b0;
      DEACT_OUT <= 1'b0;
    end else begin
      DROP_OUT <= act.drop;
      DEACT_OUT <= act.deact;
    end
  end

  // ------------------------------------------------------------
  // Answer strobes
  // ------------------------------------------------------------
  always_comb begin
    ACK_OUT = 1'h0;
    UNDEF_OUT = 1'h0;
    case (acc_r)
      ACC_DONE: begin
        ACK_OUT = 1'h1;
      end
      ACC_UNDEF: begin
        UNDEF_OUT = 1'h1;
      end
      default: begin
        ACK_OUT = 1'h0;
      end
    endcase
  end

  assign RDATA_OUT = rdata_r;
endmodule
`default_nettype wire

/* cpu_if_ctl_defs.svh */
`ifndef CPU_IF_CTL_DEFS_SVH
`define CPU_IF_CTL_DEFS_SVH
// Field positions of the top control register
`define FLD_SHARED_S 0
`define FLD_SHARED_NS 1
`define FLD_SPLIT_TOP 2
`define FLD_SPLIT_S 3
`define FLD_SPLIT_NS 4
// Bit positions inside the EL1 control view
`define FLD_VIEW_SHARED 0
`define FLD_VIEW_SPLIT 1
`define CTL_W 64
`define CTL_RW_MASK 64'h0000_0000_0000_001F
`define CTL_RESET 64'h0000_0000_0000_0000
// System register encoding op0,op1,CRn,CRm,op2
`define ENC_TOP_CTL 16'hF664
`define ENC_EL1_CTL 16'hC664
`define BPR_W 3
`define BPR_RESET 3'h0
`endif

/* cpu_if_ctl_pkg.sv */
`default_nettype none
package cpu_if_ctl_pkg;
  typedef enum logic [1:0] {
    EL_0 = 2'b00,
    EL_1 = 2'b01,
    EL_2 = 2'b10,
    EL_3 = 2'b11
  } exc_level_t;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_DONE = 2'b01,
    ACC_UNDEF = 2'b10
  } acc_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] enc;
    logic [63:0] wdata;
  } sysreg_req_t;
  typedef struct packed {
    logic drop;
    logic deact;
  } completion_act_t;
endpackage
`default_nettype wire

/* completion_decode.sv */
`include "cpu_if_ctl_defs.svh"
`default_nettype none
module completion_decode
  import cpu_if_ctl_pkg::*;
(
  input wire logic split_in,
  input wire logic eoi_in,
  input wire logic dir_in,
  output completion_act_t act_out
);
  always_comb begin
    // Split mode: completion only drops priority
    act_out.drop = eoi_in;
    // Combined mode ignores the separate deactivate write (unpredictable there)
    act_out.deact = split_in ? dir_in : eoi_in;
  end
endmodule
`default_nettype wire

/* bp_ctrl_chk.sv */
`include "cpu_if_ctl_defs.svh"
`default_nettype none
module bp_ctrl_chk
  import cpu_if_ctl_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire exc_level_t EL_IN,
  input wire sysreg_req_t REQ_IN,
  input wire logic EOI_IN,
  input wire logic DIR_IN,
  input wire logic TOP_LEVEL_INT_IN,
  input wire logic ACK_OUT,
  input wire logic UNDEF_OUT,
  input wire logic [63:0] RDATA_OUT,
  input wire logic DROP_OUT,
  input wire logic DEACT_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Shadow of the split completion bit
  // ----------------------------------------
  logic split_r;
  wire logic top_hit = REQ_IN.valid && REQ_IN.enc == `ENC_TOP_CTL;
  wire logic top_bad = top_hit && EL_IN != EL_3;
  // Only top level writes move it; lower views hold their own bits
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) split_r <= 1'h0;
    else if (top_hit && REQ_IN.write && !top_bad) split_r <= REQ_IN.wdata[`FLD_SPLIT_TOP];
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  a_top_refused: assert property (top_bad |=> UNDEF_OUT && !ACK_OUT)
    else $error("low level top access not refused");
  a_top_accepted: assert property (top_hit && !top_bad |=> ACK_OUT && !UNDEF_OUT)
    else $error("top level access not accepted");
  a_refused_hold: assert property (top_bad |=> $stable(RDATA_OUT))
    else $error("refused access moved read data");
  a_upper_zero: assert property (ACK_OUT |-> RDATA_OUT[63:5] == 59'h0)
    else $error("unused control bits read nonzero");
  a_eoi_drop: assert property (EOI_IN |=> DROP_OUT)
    else $error("completion gave no priority drop");
  a_joint_deact: assert property (EOI_IN && TOP_LEVEL_INT_IN && !split_r |=> DEACT_OUT)
    else $error("combined completion did not deactivate");
  a_split_keep: assert property (EOI_IN && TOP_LEVEL_INT_IN && split_r && !DIR_IN |=> !DEACT_OUT)
    else $error("split completion deactivated");
  a_dir_deact: assert property (DIR_IN && TOP_LEVEL_INT_IN && split_r |=> DEACT_OUT)
    else $error("deactivate write ignored in split mode");
  c_ack: cover property (ACK_OUT);
  c_undef: cover property (UNDEF_OUT);
  c_deact: cover property (DEACT_OUT && split_r);
endmodule
bind cpu_if_el3_binary_point_ctrl bp_ctrl_chk chk_u (.CLK_IN, .RST_IN, .EL_IN, .REQ_IN,
  .EOI_IN, .DIR_IN, .TOP_LEVEL_INT_IN, .ACK_OUT, .UNDEF_OUT, .RDATA_OUT, .DROP_OUT, .DEACT_OUT);
`default_nettype wire

/* testbench.sv */
`include "cpu_if_ctl_defs.svh"
`default_nettype none
module testbench
  import cpu_if_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    exc_level_t el; logic s; logic w; logic [15:0] e; logic [63:0] d; logic a; logic [7:0] r;
  } row_t;
  localparam logic [15:0] tc = `ENC_TOP_CTL;
  localparam logic [15:0] vc = `ENC_EL1_CTL;
  logic clk = 1'h0, rst = 1'h1, sec = 1'h0, bpw = 1'h0, eoi = 1'h0, dir = 1'h0;
  logic bp1 = 1'h1, top = 1'h1;
  logic ack, undef, drop, deact;
  logic [2:0] bpd = 3'h0, g0, g1, bpr;
  logic [63:0] rdata;
  exc_level_t el = EL_3;
  sysreg_req_t req = '0;
  int num_errors = 0, comparisons = 0;
  // -------------------------------
  // Access table: level, world, write, code, data, accepted, read back
  // -------------------------------
  row_t rows [8] = '{'{EL_3, 1'h0, 1'h1, tc, 64'hFFFF_FFFF_FFFF_FFFF, 1'h1, 8'h00},
    '{EL_3, 1'h0, 1'h0, tc, 64'h0, 1'h1, 8'h1F}, '{EL_2, 1'h0, 1'h1, tc, 64'h0, 1'h0, 8'h1F},
    '{EL_0, 1'h0, 1'h0, tc, 64'h0, 1'h0, 8'h1F}, '{EL_1, 1'h0, 1'h1, vc, 64'h0, 1'h1, 8'h03},
    '{EL_3, 1'h0, 1'h0, tc, 64'h0, 1'h1, 8'h0D}, '{EL_1, 1'h1, 1'h1, vc, 64'h0, 1'h1, 8'h03},
    '{EL_3, 1'h0, 1'h0, tc, 64'h0, 1'h1, 8'h04}};
  cpu_if_el3_binary_point_ctrl dut_u (.CLK_IN(clk), .RST_IN(rst), .EL_IN(el), .SECURE_IN(sec),
    .REQ_IN(req), .BP1_ACCESS_IN(bp1), .BP_WRITE_IN(bpw), .BP_WDATA_IN(bpd), .EOI_IN(eoi),
    .DIR_IN(dir), .TOP_LEVEL_INT_IN(top), .ACK_OUT(ack), .UNDEF_OUT(undef), .RDATA_OUT(rdata),
    .BP_RDATA_OUT(bpr), .GROUP1_POINT_OUT(g1), .GROUP0_POINT_OUT(g0), .DROP_OUT(drop),
    .DEACT_OUT(deact));
  always #20 clk = ~clk;
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input row_t r);
    @(posedge clk);
    req <= '{1'h1, r.w, r.e, r.d};
    el <= r.el;
    sec <= r.s;
    @(posedge clk);
    req.valid <= 1'h0;
    #1;
  endtask
  // Pulses EOI, DIR and the write strobe; the group1 view select is held on its own
  task automatic pulse(input logic e, input logic d, input logic w, input logic [2:0] v);
    @(posedge clk);
    eoi <= e;
    dir <= d;
    bpw <= w;
    bpd <= v;
    @(posedge clk);
    eoi <= 1'h0;
    dir <= 1'h0;
    bpw <= 1'h0;
    #1;
  endtask
  task automatic end_of_test;
    $display("num_errors=%0d comparisons=%0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk(80'({ack, undef, drop, deact, g0, g1, bpr, rdata}), 80'h0);
    @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      acc(rows[i]);
      chk(80'({ack, undef, rdata}), 80'({rows[i].a, ~rows[i].a, 56'h0, rows[i].r}));
    end
    pulse(1'h1, 1'h0, 1'h0, 3'h0);
    chk(80'({drop, deact}), 80'h2);
    pulse(1'h0, 1'h1, 1'h0, 3'h0);
    chk(80'(deact), 80'h1);
    acc('{EL_3, 1'h0, 1'h1, tc, 64'h3, 1'h1, 8'h0});
    pulse(1'h1, 1'h0, 1'h0, 3'h0);
    chk(80'({drop, deact}), 80'h3);
    pulse(1'h0, 1'h1, 1'h0, 3'h0);
    chk(80'(deact), 80'h0);
    acc('{EL_1, 1'h0, 1'h0, 16'h0, 64'h0, 1'h0, 8'h0});
    pulse(1'h0, 1'h0, 1'h1, 3'h5);
    @(posedge clk);
    #1;
    chk(80'({g0, g1, bpr}), 80'h16D);
    acc('{EL_1, 1'h1, 1'h0, 16'h0, 64'h0, 1'h0, 8'h0});
    pulse(1'h0, 1'h0, 1'h1, 3'h6);
    @(posedge clk);
    #1;
    chk(80'({g0, g1, bpr}), 80'h1B6);
    acc('{EL_1, 1'h1, 1'h1, vc, 64'h0, 1'h1, 8'h0});
    pulse(1'h0, 1'h0, 1'h1, 3'h2);
    @(posedge clk);
    #1;
    chk(80'({g0, g1, bpr}), 80'h192);
    // Non-secure world with separate points
    acc('{EL_3, 1'h0, 1'h1, tc, 64'h0, 1'h1, 8'h0});
    pulse(1'h0, 1'h0, 1'h1, 3'h1);
    @(posedge clk);
    #1;
    chk(80'({g0, g1, bpr}), 80'h189);
    @(posedge clk);
    bp1 <= 1'h0;
    pulse(1'h0, 1'h0, 1'h1, 3'h4);
    @(posedge clk);
    #1;
    chk(80'({g0, g1, bpr}), 80'h10C);
    // Top-level completion follows bit 2, others their world's bit
    acc('{EL_3, 1'h0, 1'h1, tc, 64'h10, 1'h1, 8'h0});
    pulse(1'h1, 1'h0, 1'h0, 3'h0);
    chk(80'({drop, deact}), 80'h3);
    @(posedge clk);
    top <= 1'h0;
    pulse(1'h1, 1'h0, 1'h0, 3'h0);
    chk(80'({drop, deact}), 80'h2);
    // Reset in mid-run clears the control bits again
    @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    #1;
    chk(80'({ack, undef, drop, deact, g0, g1, bpr, rdata}), 80'h0);
    @(posedge clk);
    rst <= 1'h0;
    acc('{EL_3, 1'h0, 1'h0, tc, 64'h0, 1'h1, 8'h0});
    chk(80'({ack, undef, rdata}), 80'h2_0000_0000_0000_0000);
    end_of_test;
  end
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
`default_nettype wire
